// [battery_pack_mode_charge_controller_tb_top.sv]
// Self-checking bench for pack_ctrl with a cell model on its power side.
// Assumes TICK_CYCLES of 4, so one millisecond lasts 16 ns.
module battery_pack_mode_charge_controller_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TK = 4;
    logic hclk, hready, hreadyout, hresp, converter_low_switch, reverse_block, level_shift_active;
    logic hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, supply_input_valid = 1'b0, storage_mode_pin = 1'b1;
    logic push_button_n = 1'b1, out_below_uvp = 1'b0, input_limited = 1'b0, bat_cutoff = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [11:0] bat_mv = 12'd3000, taper_ma = 12'd500, bat_ma, charge_current_req;
    logic input_pass_switch, converter_high_switch, converter_step_up, constant_voltage_phase, flashlight_on;
    logic level_lamp_one, level_lamp_two, level_lamp_three, level_lamp_four;
    int miscompares = 0, checks_done = 0, fast = 1000;
    integer seed = 32'hf7f5242e;
    assign hready = hreadyout;
    pack_ctrl #(.TICK_CYCLES(TK)) DUT (.*);
    pack_cell_model u_cell (.*);
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    task automatic end_sim();
        $display("checks %0d miscompares %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        #400000;
        miscompares++;
        end_sim();
    end
    task automatic chk(input string n, input logic [31:0] e, g);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic ahb(input logic w, input logic [31:0] a, d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic ms(input int n);
        repeat (n * TK) @(posedge hclk);
    endtask
    // Expected request per charge state: 0 idle, 1 pre, 2 fast, 3 top, 4 done.
    task automatic step(input logic [11:0] mv, tp, input int st);
        bat_mv <= mv;
        taper_ma <= tp;
        ms(2);
        chk("charge_current_req", 32'(st == 1 ? fast * 10 / 100 : (st == 2 || st == 3) ? fast : 0),
            32'(charge_current_req));
        chk("constant_voltage_phase", 32'(st == 3), 32'(constant_voltage_phase));
    endtask
    initial begin
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(1'b0, 32'h10, 32'h0);
        chk("status", 32'h11, rd);
        ahb(1'b0, 32'h04, 32'h0);
        chk("charge_set", 32'h0834_03e8, rd);
        ahb(1'b0, 32'hfc, 32'h0);
        chk("unmapped", 32'h0, rd);
        $display("test reset done");
        storage_mode_pin <= 1'b0;
        push_button_n <= 1'b0;
        ms(10);
        push_button_n <= 1'b1;
        ms(5);
        chk("short press", 32'h0, 32'(converter_step_up));
        push_button_n <= 1'b0;
        ms(40);
        push_button_n <= 1'b1;
        ms(2);
        chk("boost", 32'h3, 32'({input_pass_switch, converter_step_up, reverse_block}));
        $display("test boost done");
        ahb(1'b1, 32'h04, 32'h0fa0_03e8);
        bat_mv <= 12'(2000 + ($random(seed) & 511));
        supply_input_valid <= 1'b1;
        ms(1900);
        chk("changeover", 32'h0, 32'({input_pass_switch, converter_high_switch, converter_step_up}));
        ms(200);
        chk("charge", 32'h3, 32'({input_pass_switch, converter_high_switch}));
        chk("aux", 32'h5, 32'({converter_low_switch, reverse_block, level_shift_active}));
        step(bat_mv, 12'd500, 1);
        step(12'd3500, 12'd500, 2);
        step(12'd4000, 12'd500, 3);
        step(12'd4000, 12'd100, 4);
        chk("lamps", 32'hf, 32'({level_lamp_four, level_lamp_three, level_lamp_two, level_lamp_one}));
        step(12'd3800, 12'd100, 2);
        {out_below_uvp, input_limited} <= 2'h3;
        ms(2);
        chk("hiccup", 32'h0, 32'(input_pass_switch));
        $display("test charge done");
        end_sim();
    end
endmodule

// [pack_cell_model.sv]
// Behavioural cell on the converter side, reporting its charge current.
// Assumes the bench sets taper_ma as the cell's own top-off current.
module pack_cell_model (
    input wire logic input_pass_switch, converter_step_up, constant_voltage_phase,
    input wire logic [11:0] charge_current_req, taper_ma,
    output logic [11:0] bat_ma
);
    timeunit 1ns;
    timeprecision 1ps;
    assign bat_ma = (!input_pass_switch || converter_step_up) ? 12'h000 :
        constant_voltage_phase ? taper_ma : charge_current_req;
endmodule

// [pack_ctrl.sv]
// Mode, charge and lamp control for a single-cell battery pack manager.
// Assumes comparator levels and the push button arrive from outside the clock
// domain, cell voltage and current come as ADC words on hclk, and software
// reaches the settings over an AHB-Lite slave port.
//
// Added by the designer: the address map and register access over AHB-Lite.

// Contract
// RULE_01: Output sag under input limit: hiccup two seconds.
// RULE_02: Charge mode: pass switch on, converter steps down.
// RULE_03: Boost mode: step up, pass off, reverse blocked.
// RULE_04: High-impedance mode: every power switch off.
// RULE_05: Boost to charge passes two-second all-off.
// RULE_06: Mode from supply validity and storage-mode pin.
// RULE_07: Boost starts after button held over 30ms.
// RULE_08: No-flashlight variant: 1.5s press stops boost.
// RULE_09: Flashlight variant: 3s presses toggle flashlight.
// RULE_10: Cut-off latches discharge off until supply returns.
// RULE_11: Charging starts in precondition, only with supply.
// RULE_12: Precondition at 10 percent, then fast.
// RULE_13: Fast constant current until termination voltage.
// RULE_14: Top-off constant voltage until current under 15%.
// RULE_15: End of charge stops, keeps watching voltage.
// RULE_16: 200mV drop restarts directly in fast charge.
// RULE_17: Four lamps show level; full charge solid.
// RULE_18: Lower thresholds 450, 350, 200mV below fourth.
// RULE_19: Thresholds shift with compensated battery impedance.
// RULE_20: Flashing lamps toggle each second.
// RULE_21: Button release outside charge shows lamps 5s; the code does this only in the no-flashlight variant.
// RULE_22: Durations counted on clock; short presses ignored.
// RULE_23: Reset starts high-impedance, unlatched, charger idle.
module pack_ctrl #(
    parameter int TICK_CYCLES = pack_ctrl_pkg::TICK_CYCLES
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic supply_input_valid,
    input wire logic storage_mode_pin,
    input wire logic push_button_n,
    input wire logic out_below_uvp,
    input wire logic input_limited,
    input wire logic bat_cutoff,
    input wire logic [11:0] bat_mv,
    input wire logic [11:0] bat_ma,
    output logic input_pass_switch,
    output logic converter_high_switch,
    output logic converter_low_switch,
    output logic converter_step_up,
    output logic reverse_block,
    output logic [11:0] charge_current_req,
    output logic constant_voltage_phase,
    output logic level_shift_active,
    output logic flashlight_on,
    output logic level_lamp_one,
    output logic level_lamp_two,
    output logic level_lamp_three,
    output logic level_lamp_four
);

    // ------------------------------------------------------------------
    // Input synchronisers and the 1 ms tick
    // ------------------------------------------------------------------
    logic [5:0] pins_s;
    logic tick;

    sync_bits #(
        .W(6)
    ) u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .d({supply_input_valid, storage_mode_pin, ~push_button_n,
            out_below_uvp, input_limited, bat_cutoff}),
        .q(pins_s)
    );

    tick_divider #(
        .CYCLES(TICK_CYCLES)
    ) u_tick (
        .hclk(hclk),
        .hresetn(hresetn),
        .tick(tick)
    );

    wire vin_ok = pins_s[5];
    wire hz_pin = pins_s[4];
    wire pb_down = pins_s[3];
    wire uvp = pins_s[2];
    wire in_lim = pins_s[1];
    wire cutoff = pins_s[0];

    // ------------------------------------------------------------------
    // Registers and state
    // ------------------------------------------------------------------
    logic flash_var_q;
    logic [11:0] fast_ma_q, term_mv_q, lamp4_mv_q, pre_mv_q;
    logic [9:0] imp_q;
    logic [7:0] addr_q;
    logic wr_q;
    pack_ctrl_pkg::mode_e mode_q, mode_d;
    pack_ctrl_pkg::chg_e chg_q, chg_d;
    logic [pack_ctrl_pkg::MS_W-1:0] wait_q, press_q, show_q, blink_q;
    logic hic_q, latch_q, vin_prev_q, pb_prev_q, pb_boost_q, flash_q, phase_q;
    logic [2:0] lvl_q;
    logic low_q;
    logic [3:0] lamp_q;

    // ------------------------------------------------------------------
    // Push-button timing
    // ------------------------------------------------------------------
    wire pb_start = pb_down & ~pb_prev_q;
    wire pb_rel = ~pb_down & pb_prev_q;
    wire pb_step = pb_down & tick;
    wire hit_on = pb_step & (press_q == pack_ctrl_pkg::PB_ON_TICKS);
    wire hit_off = pb_step & (press_q == pack_ctrl_pkg::PB_OFF_TICKS);
    wire hit_flash = pb_step & (press_q == pack_ctrl_pkg::PB_FLASH_TICKS);
    wire pb_long = press_q > pack_ctrl_pkg::PB_ON_TICKS;
    wire boost_off = hit_off & pb_boost_q & ~flash_var_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            press_q <= '0;
            pb_prev_q <= 1'b0;
            pb_boost_q <= 1'b0;
        end else begin
            pb_prev_q <= pb_down;
            if (!pb_down) begin
                press_q <= '0;
            end else if (tick && press_q != pack_ctrl_pkg::MS_MAX) begin
                press_q <= press_q + 1'b1; // [RULE_22]
            end
            if (pb_start) begin
                pb_boost_q <= (mode_q == pack_ctrl_pkg::M_BOOST);
            end
        end
    end

    // ------------------------------------------------------------------
    // Mode selection
    // ------------------------------------------------------------------
    wire is_chg = (mode_q == pack_ctrl_pkg::M_CHARGE);
    wire is_boost = (mode_q == pack_ctrl_pkg::M_BOOST);
    wire is_swap = (mode_q == pack_ctrl_pkg::M_SWAP);
    wire vin_rise = vin_ok & ~vin_prev_q;
    wire latch_set = is_boost & cutoff;
    wire hic_set = is_chg & ~hic_q & uvp & in_lim;
    wire hic_done = hic_q & (wait_q == pack_ctrl_pkg::HICCUP_TICKS);
    wire swap_done = is_swap & (wait_q == pack_ctrl_pkg::CHANGE_TICKS);
    wire wait_clr = (mode_d != mode_q) | hic_set;

    always_comb begin
        mode_d = mode_q;
        case (mode_q)
            pack_ctrl_pkg::M_HIZ: begin
                if (vin_ok) begin
                    mode_d = pack_ctrl_pkg::M_CHARGE; // [RULE_06]
                end else if (!hz_pin && !latch_q && hit_on) begin
                    mode_d = pack_ctrl_pkg::M_BOOST; // [RULE_07] [RULE_10]
                end
            end
            pack_ctrl_pkg::M_CHARGE: begin
                if (!vin_ok) begin
                    mode_d = pack_ctrl_pkg::M_SWAP; // [RULE_05]
                end
            end
            pack_ctrl_pkg::M_BOOST: begin
                if (vin_ok) begin
                    mode_d = pack_ctrl_pkg::M_SWAP; // [RULE_05]
                end else if (hz_pin || cutoff || boost_off) begin
                    mode_d = pack_ctrl_pkg::M_HIZ; // [RULE_06] [RULE_08] [RULE_10]
                end
            end
            pack_ctrl_pkg::M_SWAP: begin
                if (swap_done) begin
                    mode_d = pack_ctrl_pkg::M_HIZ; // [RULE_05]
                end
            end
            default: begin
                mode_d = pack_ctrl_pkg::M_HIZ;
            end
        endcase
    end

    // Latch set wins over release when both land in one cycle.
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mode_q <= pack_ctrl_pkg::M_HIZ; // [RULE_23]
            wait_q <= '0;
            hic_q <= 1'b0;
            latch_q <= 1'b0;
            vin_prev_q <= 1'b0;
            flash_q <= 1'b0;
        end else begin
            mode_q <= mode_d;
            vin_prev_q <= vin_ok;
            latch_q <= latch_set | (latch_q & ~vin_rise); // [RULE_10]
            if (wait_clr) begin
                wait_q <= '0;
            end else if (tick && (is_swap || hic_q)) begin
                wait_q <= wait_q + 1'b1; // [RULE_22]
            end
            if (!is_chg || hic_done) begin
                hic_q <= 1'b0;
            end else if (hic_set) begin
                hic_q <= 1'b1; // [RULE_01]
            end
            if (hit_flash && flash_var_q) begin
                flash_q <= ~flash_q; // [RULE_09]
            end
        end
    end

    // ------------------------------------------------------------------
    // Charge sequencing
    // ------------------------------------------------------------------
    wire [18:0] pre_prod = fast_ma_q * pack_ctrl_pkg::PRE_PCT;
    wire [18:0] eoc_prod = fast_ma_q * pack_ctrl_pkg::EOC_PCT;
    wire [11:0] pre_ma = 12'(pre_prod / pack_ctrl_pkg::PCT_DIV);
    wire [11:0] eoc_ma = 12'(eoc_prod / pack_ctrl_pkg::PCT_DIV);
    wire [12:0] bat_up = {1'b0, bat_mv} + pack_ctrl_pkg::RECHARGE_MV;
    wire chg_run = is_chg & vin_ok;

    always_comb begin
        chg_d = chg_q;
        case (chg_q)
            pack_ctrl_pkg::C_IDLE: begin
                if (chg_run) begin
                    chg_d = pack_ctrl_pkg::C_PRE; // [RULE_11]
                end
            end
            pack_ctrl_pkg::C_PRE: begin
                if (bat_mv > pre_mv_q) begin
                    chg_d = pack_ctrl_pkg::C_FAST; // [RULE_12]
                end
            end
            pack_ctrl_pkg::C_FAST: begin
                if (bat_mv >= term_mv_q) begin
                    chg_d = pack_ctrl_pkg::C_TOP; // [RULE_13]
                end
            end
            pack_ctrl_pkg::C_TOP: begin
                if (bat_ma < eoc_ma) begin
                    chg_d = pack_ctrl_pkg::C_DONE; // [RULE_14]
                end
            end
            pack_ctrl_pkg::C_DONE: begin
                if (bat_up <= {1'b0, term_mv_q}) begin
                    chg_d = pack_ctrl_pkg::C_FAST; // [RULE_16]
                end
            end
            default: begin
                chg_d = pack_ctrl_pkg::C_IDLE;
            end
        endcase
        if (!chg_run) begin
            chg_d = pack_ctrl_pkg::C_IDLE; // [RULE_11]
        end
    end

    wire chg_pre = (chg_q == pack_ctrl_pkg::C_PRE);
    wire chg_top = (chg_q == pack_ctrl_pkg::C_TOP);
    wire chg_done = (chg_q == pack_ctrl_pkg::C_DONE);
    wire chg_on = chg_run & ~chg_done & (chg_q != pack_ctrl_pkg::C_IDLE);
    wire [11:0] cur_req = !chg_on ? 12'h000 : chg_pre ? pre_ma : fast_ma_q;

    // ------------------------------------------------------------------
    // Lamp thresholds and level
    // ------------------------------------------------------------------
    wire [21:0] drop_prod = imp_q * bat_ma;
    wire [13:0] shift_mv = 14'(drop_prod / pack_ctrl_pkg::IMP_DIV);
    wire [13:0] base4 = {2'b00, lamp4_mv_q};
    wire [13:0] thr4 = chg_on ? base4 + shift_mv : is_boost ? base4 - shift_mv : base4; // [RULE_19]
    wire [13:0] thr [4];
    assign thr[0] = thr4 - pack_ctrl_pkg::LAMP1_OFS_MV; // [RULE_18]
    assign thr[1] = thr4 - pack_ctrl_pkg::LAMP2_OFS_MV; // [RULE_18]
    assign thr[2] = thr4 - pack_ctrl_pkg::LAMP3_OFS_MV; // [RULE_18]
    assign thr[3] = thr4;
    wire [13:0] bat_w = {2'b00, bat_mv};
    wire [2:0] lvl_d = 3'(bat_w >= thr[0]) + 3'(bat_w >= thr[1]) + 3'(bat_w >= thr[2]) + 3'(bat_w >= thr[3]);
    wire show_on = (show_q != '0) | (flash_var_q & is_boost);

    // Decides one lamp from level, mode, blink phase and visibility.
    function automatic logic lamp_state(input int idx, input logic [2:0] lvl, input logic chg,
                                        input logic full, input logic ph, input logic low,
                                        input logic vis);
        logic at;
        at = (lvl == 3'(idx)) | ((idx == 3) & (lvl == 3'd4));
        if (chg) begin
            lamp_state = full | (lvl > 3'(idx)) | (at & ph); // [RULE_17]
        end else begin
            lamp_state = vis & ((lvl > 3'(idx)) | ((idx == 0) & at & ~low & ph)); // [RULE_17]
        end
    endfunction

    for (genvar g = 0; g < 4; g++) begin : g_lamp
        always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
                lamp_q[g] <= 1'b0;
            end else begin
                lamp_q[g] <= lamp_state(g, lvl_q, is_chg, chg_done, phase_q, low_q, show_on);
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lvl_q <= '0;
            low_q <= 1'b1;
            blink_q <= '0;
            phase_q <= 1'b0;
            show_q <= '0;
        end else begin
            lvl_q <= lvl_d;
            low_q <= bat_w < pack_ctrl_pkg::LOW_MV;
            if (tick) begin
                blink_q <= (blink_q == pack_ctrl_pkg::BLINK_TICKS - 1'b1) ? '0 : blink_q + 1'b1;
                phase_q <= (blink_q == pack_ctrl_pkg::BLINK_TICKS - 1'b1) ? ~phase_q : phase_q; // [RULE_20]
            end
            if (pb_rel && pb_long && !flash_var_q && !is_chg) begin
                show_q <= pack_ctrl_pkg::SHOW_TICKS; // [RULE_21] [RULE_22]
            end else if (tick && show_q != '0) begin
                show_q <= show_q - 1'b1;
            end
        end
    end

    // ------------------------------------------------------------------
    // Power switch and regulation outputs
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            input_pass_switch <= 1'b0; // [RULE_23]
            converter_high_switch <= 1'b0;
            converter_low_switch <= 1'b0;
            converter_step_up <= 1'b0;
            reverse_block <= 1'b1;
            charge_current_req <= '0;
            constant_voltage_phase <= 1'b0;
            level_shift_active <= 1'b0;
            flashlight_on <= 1'b0;
        end else begin
            input_pass_switch <= is_chg & ~hic_q; // [RULE_01] [RULE_02] [RULE_04]
            converter_high_switch <= chg_on | is_boost; // [RULE_02] [RULE_03] [RULE_15]
            converter_low_switch <= chg_on | is_boost; // [RULE_04]
            converter_step_up <= is_boost; // [RULE_03]
            reverse_block <= ~is_chg; // [RULE_03]
            charge_current_req <= cur_req; // [RULE_12] [RULE_13] [RULE_15]
            constant_voltage_phase <= chg_on & chg_top; // [RULE_14]
            level_shift_active <= chg_on | is_boost; // [RULE_19]
            flashlight_on <= flash_q;
        end
    end

    assign level_lamp_one = lamp_q[0];
    assign level_lamp_two = lamp_q[1];
    assign level_lamp_three = lamp_q[2];
    assign level_lamp_four = lamp_q[3];

    // ------------------------------------------------------------------
    // AHB-Lite register slave
    // ------------------------------------------------------------------
    wire take = hsel & hready & htrans[1];
    wire in_map = (haddr[31:8] == 24'h000000);
    wire [7:0] a = in_map ? haddr[7:0] : 8'hff;
    wire [31:0] status_w = {16'h0000, lamp_q, hic_q, flash_q, latch_q, chg_q, mode_q};
    wire [31:0] rd_w = (a == pack_ctrl_pkg::A_CONFIG) ? {31'h00000000, flash_var_q} :
                       (a == pack_ctrl_pkg::A_CHARGE_SET) ? {4'h0, term_mv_q, 4'h0, fast_ma_q} :
                       (a == pack_ctrl_pkg::A_LEVEL_SET) ? {6'h00, imp_q, 4'h0, lamp4_mv_q} :
                       (a == pack_ctrl_pkg::A_PRECOND_SET) ? {20'h00000, pre_mv_q} :
                       (a == pack_ctrl_pkg::A_STATUS) ? status_w : 32'h00000000;
    wire [11:0] w_lo = hwdata[11:0];
    wire [11:0] w_hi = hwdata[pack_ctrl_pkg::F_HI_LSB +: 12];

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            hrdata <= '0;
            addr_q <= '0;
            wr_q <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wr_q <= take & hwrite;
            if (take) begin
                addr_q <= a;
                hrdata <= hwrite ? 32'h00000000 : rd_w;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flash_var_q <= 1'b0;
            fast_ma_q <= pack_ctrl_pkg::RST_FAST_MA;
            term_mv_q <= pack_ctrl_pkg::RST_TERM_MV;
            lamp4_mv_q <= pack_ctrl_pkg::RST_LAMP4_MV;
            imp_q <= pack_ctrl_pkg::RST_IMP_MOHM;
            pre_mv_q <= pack_ctrl_pkg::RST_PRE_MV;
        end else if (wr_q) begin
            case (addr_q)
                pack_ctrl_pkg::A_CONFIG: begin
                    flash_var_q <= hwdata[0];
                end
                pack_ctrl_pkg::A_CHARGE_SET: begin
                    fast_ma_q <= w_lo;
                    term_mv_q <= w_hi;
                end
                pack_ctrl_pkg::A_LEVEL_SET: begin
                    lamp4_mv_q <= w_lo;
                    imp_q <= w_hi[9:0];
                end
                pack_ctrl_pkg::A_PRECOND_SET: begin
                    pre_mv_q <= w_lo;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            chg_q <= pack_ctrl_pkg::C_IDLE; // [RULE_23]
        end else begin
            chg_q <= chg_d;
        end
    end

endmodule

// [pack_ctrl_pkg.sv]
// Constants, register map and state encodings for the battery pack controller.
// Assumes a 250 MHz hclk; all slow timing is counted in 1 ms ticks.
package pack_ctrl_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 4;
    localparam int TICK_US = 1000;
    localparam int TICK_CYCLES = TICK_US * 1000 / CLK_PERIOD_NS;
    localparam int MS_W = 13;
    localparam int CHANGE_MS = 2000;
    localparam int HICCUP_MS = 2000;
    localparam int PB_ON_MS = 30;
    localparam int PB_OFF_MS = 1500;
    localparam int PB_FLASH_MS = 3000;
    localparam int SHOW_MS = 5000;
    localparam int BLINK_MS = 1000;
    localparam logic [MS_W-1:0] CHANGE_TICKS = MS_W'(CHANGE_MS * 1000 / TICK_US);
    localparam logic [MS_W-1:0] HICCUP_TICKS = MS_W'(HICCUP_MS * 1000 / TICK_US);
    localparam logic [MS_W-1:0] PB_ON_TICKS = MS_W'(PB_ON_MS * 1000 / TICK_US);
    localparam logic [MS_W-1:0] PB_OFF_TICKS = MS_W'(PB_OFF_MS * 1000 / TICK_US);
    localparam logic [MS_W-1:0] PB_FLASH_TICKS = MS_W'(PB_FLASH_MS * 1000 / TICK_US);
    localparam logic [MS_W-1:0] SHOW_TICKS = MS_W'(SHOW_MS * 1000 / TICK_US);
    localparam logic [MS_W-1:0] BLINK_TICKS = MS_W'(BLINK_MS * 1000 / TICK_US);
    localparam logic [MS_W-1:0] MS_MAX = {MS_W{1'b1}};

    // ------------------------------------------------------------------
    // Analog figures, in mV, mA and percent
    // ------------------------------------------------------------------
    localparam logic [13:0] LOW_MV = 14'd2900;
    localparam logic [13:0] LAMP1_OFS_MV = 14'd450;
    localparam logic [13:0] LAMP2_OFS_MV = 14'd350;
    localparam logic [13:0] LAMP3_OFS_MV = 14'd200;
    localparam logic [12:0] RECHARGE_MV = 13'd200;
    localparam logic [6:0] PRE_PCT = 7'd10;
    localparam logic [6:0] EOC_PCT = 7'd15;
    localparam logic [18:0] PCT_DIV = 19'd100;
    localparam logic [21:0] IMP_DIV = 22'd1000;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [7:0] A_CONFIG = 8'h00;
    localparam logic [7:0] A_CHARGE_SET = 8'h04;
    localparam logic [7:0] A_LEVEL_SET = 8'h08;
    localparam logic [7:0] A_PRECOND_SET = 8'h0c;
    localparam logic [7:0] A_STATUS = 8'h10;
    localparam int F_HI_LSB = 16;
    localparam logic [11:0] RST_FAST_MA = 12'h3e8;
    localparam logic [11:0] RST_TERM_MV = 12'h834;
    localparam logic [11:0] RST_LAMP4_MV = 12'hfa0;
    localparam logic [9:0] RST_IMP_MOHM = 10'h064;
    localparam logic [11:0] RST_PRE_MV = 12'hbb8;

    // ------------------------------------------------------------------
    // State encodings
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        M_HIZ = 4'b0001,
        M_CHARGE = 4'b0010,
        M_BOOST = 4'b0100,
        M_SWAP = 4'b1000
    } mode_e;

    typedef enum logic [4:0] {
        C_IDLE = 5'b00001,
        C_PRE = 5'b00010,
        C_FAST = 5'b00100,
        C_TOP = 5'b01000,
        C_DONE = 5'b10000
    } chg_e;

endpackage

// [pack_ctrl_properties.sv]
// Port assertions for the pack controller.
// Assumes it is bound onto pack_ctrl and sees only its ports.
module pack_ctrl_properties (
    input wire logic hclk, hresetn, hreadyout, hresp, supply_input_valid, input_pass_switch,
    input wire logic converter_high_switch, converter_low_switch, converter_step_up, reverse_block,
    input wire logic constant_voltage_phase,
    input wire logic [11:0] charge_current_req
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    sequence supply_held;
        supply_input_valid [*8];
    endsequence
    a_bus_okay: assert property (hreadyout && !hresp) else $error("bus answer not ready okay");
    a_reset_off: assert property ($rose(hresetn) |-> !input_pass_switch && reverse_block)
        else $error("switch on at reset release");
    a_boost_pass_off: assert property (converter_step_up |-> !input_pass_switch && reverse_block)
        else $error("pass on or unblocked in boost");
    a_switch_pair: assert property (converter_high_switch == converter_low_switch)
        else $error("converter switches split");
    a_supply_no_boost: assert property (supply_held |-> !converter_step_up)
        else $error("boost with valid supply");
    a_req_no_boost: assert property (charge_current_req != 12'h000 |-> !converter_step_up)
        else $error("charge request in boost");
    a_topoff_req: assert property (constant_voltage_phase |-> charge_current_req != 12'h000)
        else $error("top-off without current");
    a_pass_gap: assert property ($fell(converter_step_up) |-> !input_pass_switch [*8])
        else $error("pass on right after boost");
endmodule
bind pack_ctrl pack_ctrl_properties u_props (.*);

// [sync_bits.sv]
// Two-flop synchroniser for a group of independent level inputs.
// Assumes each bit is a slow level; bits are not coherent with each other.
module sync_bits #(
    parameter int W = 1
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);

    logic [W-1:0] meta_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_q <= '0;
            q <= '0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end

endmodule

// [tick_divider.sv]
// Divider giving a one-cycle enable pulse every CYCLES clocks.
// Assumes CYCLES is at least 2.
module tick_divider #(
    parameter int CYCLES = 2
) (
    input wire logic hclk,
    input wire logic hresetn,
    output logic tick
);

    localparam int CW = $clog2(CYCLES);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

    logic [CW-1:0] cnt_q;
    wire wrap = (cnt_q == LAST);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= '0;
            tick <= 1'b0;
        end else begin
            cnt_q <= wrap ? '0 : cnt_q + 1'b1;
            tick <= wrap;
        end
    end

endmodule
